/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import uart_pkg::*;
  localparam line_cfg_t cfg8 = '{2'h3, STOP_ONE, PAR_NONE, 1'b0};
  logic        mclk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        clk24_in = 1'b0;
  logic        clk16_in = 1'b0;
  logic        src16_sel_in = 1'b0;
  logic [15:0] divisor_in = 16'h0001;
  line_cfg_t   line_cfg_in = cfg8;
  logic        fifo_en_in = 1'b0;
  logic [1:0]  rx_trig_in = 2'h0;
  logic [3:0]  irq_en_in = 4'h0;
  logic [7:0]  tx_data_in = 8'h00;
  logic        tx_write_in = 1'b0;
  logic        rx_read_in = 1'b0;
  logic        tx_full_out, rx_valid_out, parity_err_out, frame_err_out;
  logic        overrun_out, irq_out, txd_out, rxd_in;
  logic [7:0]  rx_data_out;
  irq_cause_t  irq_cause_out;
  logic [31:0] bit_cyc = 32'h0000_0040;
  int          fails = 0;
  int          checked = 0;
  int          ph = 0;
  int          tick = 4;

  always #25 mclk_in = ~mclk_in;
  // Slow stand-ins for the two baud sources, 4 and 6 cycles per edge
  always @(negedge mclk_in) begin
    ph <= ph + 1;
    clk24_in <= (ph % 4) < 2;
    clk16_in <= (ph % 6) < 3;
  end

  uart_core uart_core_inst (.mclk_in, .rstn_in, .clk24_in, .clk16_in,
    .src16_sel_in, .divisor_in, .line_cfg_in, .fifo_en_in, .rx_trig_in,
    .irq_en_in, .tx_data_in, .tx_write_in, .tx_full_out, .rx_data_out,
    .rx_valid_out, .rx_read_in, .parity_err_out, .frame_err_out,
    .overrun_out, .irq_cause_out, .irq_out, .txd_out, .rxd_in);
  uart_remote_model uart_remote_model_inst (.mclk_in, .txd_in(txd_out),
    .rxd_out(rxd_in), .bit_cyc_in(bit_cyc));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Lets the line settle before the format changes
  task automatic setup(input logic s16, input logic [15:0] dv,
                       input line_cfg_t c, input logic fe);
    repeat (bit_cyc * 3) @(negedge mclk_in);
    src16_sel_in = s16;
    divisor_in = dv;
    line_cfg_in = c;
    fifo_en_in = fe;
    tick = (s16 ? 6 : 4) * dv;
    bit_cyc = 16 * tick;
  endtask

  task automatic wrn(input logic [7:0] d, input int n);
    @(negedge mclk_in);
    tx_write_in = 1'b1;
    for (int i = 0; i < n; i++) begin
      tx_data_in = d + 8'(i);
      @(negedge mclk_in);
    end
    tx_write_in = 1'b0;
  endtask

  task automatic rd;
    @(negedge mclk_in);
    rx_read_in = 1'b1;
    @(negedge mclk_in);
    rx_read_in = 1'b0;
    repeat (3) @(negedge mclk_in);
  endtask

  task automatic tx_pair(input line_cfg_t c, input logic [7:0] d);
    logic [7:0] g0, g1, m;
    logic p0, p1;
    int t0, t1, fr;
    m = 8'hff >> (2'h3 - c.word_len);
    fr = tick * ((6 + c.word_len + (c.parity != PAR_NONE)) * 16
         + uart_remote_model_inst.stop_ticks(c));
    fork
      wrn(d, 2);
      begin
        uart_remote_model_inst.recv(c, g0, p0, t0);
        uart_remote_model_inst.recv(c, g1, p1, t1);
      end
    join
    chk(g0, d & m);
    chk(g1, (d + 8'h01) & m);
    if (c.parity != PAR_NONE) begin
      chk(p1, uart_remote_model_inst.par_bit(c, d + 8'h01));
    end
    chk((t1 - t0 >= fr) && (t1 - t0 <= fr + tick), 1'b1);
  endtask

  task automatic t_tx_formats;
    line_cfg_t c;
    for (int k = 0; k < 16; k++) begin
      c.word_len = 2'(k / 4);
      c.parity = parity_t'(k % 4);
      c.stop_len = stop_t'((k / 4 + k) % 3);
      c.sticky_val = k[3];
      setup(1'b0, 16'h0001, c, 1'b1);
      tx_pair(c, 8'h96 ^ 8'(k * 37));
    end
    for (int r = 0; r < 2; r++) begin
      setup(r == 0, 16'(2 + 2 * r), cfg8, 1'b1);
      tx_pair(cfg8, 8'h3c);
    end
  endtask

  task automatic t_rx;
    line_cfg_t c;
    for (int k = 0; k < 6; k++) begin
      c.word_len = 2'(k);
      c.parity = parity_t'(k < 4 ? k : 2);
      c.stop_len = STOP_TWO;
      c.sticky_val = 1'b1;
      irq_en_in = 4'h7;
      setup(1'b0, 16'h0001, c, 1'b0);
      uart_remote_model_inst.send(c, 8'h5a + 8'(k), k == 4, k == 5);
      for (int i = 0; i < 200 && rx_valid_out !== 1'b1; i++)
        @(negedge mclk_in);
      repeat (4) @(negedge mclk_in);
      chk(rx_data_out, (8'h5a + 8'(k)) & (8'hff >> (2'h3 - c.word_len)));
      chk({parity_err_out, frame_err_out}, {k == 4, k == 5});
      if (k > 3) chk(irq_cause_out, IRQ_LINE);
      else chk(irq_cause_out, IRQ_RXDATA);
      rd;
      chk({rx_valid_out, parity_err_out, frame_err_out}, 3'h0);
    end
    uart_remote_model_inst.drive(1'b0, 5);
    uart_remote_model_inst.drive(1'b1, bit_cyc * 12);
    chk({rx_valid_out, frame_err_out}, 2'h0);
  endtask

  task automatic t_rx_fifo;
    irq_en_in = 4'h1;
    rx_trig_in = 2'h1;
    setup(1'b0, 16'h0001, cfg8, 1'b1);
    for (int i = 0; i < 19; i++) begin
      if (i == 3) chk(irq_cause_out == IRQ_RXDATA, 1'b0);
      if (i == 4) chk(irq_cause_out, IRQ_RXDATA);
      uart_remote_model_inst.send(cfg8, 8'h10 + 8'(i), 1'b0, 1'b0);
      repeat (8) @(negedge mclk_in);
    end
    // FIFO, two-entry buffer and the finished word hold 19; the last stalls
    chk(overrun_out, 1'b1);
    for (int i = 0; i < 19; i++) begin
      chk(rx_data_out, 8'h10 + 8'(i));
      rd;
    end
    chk(rx_valid_out, 1'b0);
    uart_remote_model_inst.send(cfg8, 8'h77, 1'b0, 1'b0);
    for (int i = 0; i < 4000 && irq_cause_out !== IRQ_TIMEOUT; i++)
      @(negedge mclk_in);
    chk(irq_cause_out, IRQ_TIMEOUT);
    rd;
  endtask

  task automatic t_tx_fifo;
    logic [7:0] g;
    logic p;
    int t, lows;
    irq_en_in = 4'h2;
    fork
      wrn(8'h40, 16);
      for (int i = 0; i < 16; i++) begin
        uart_remote_model_inst.recv(cfg8, g, p, t);
        chk(g, 8'h40 + 8'(i));
      end
    join
    lows = 0;
    repeat (2000) @(posedge mclk_in) lows += (txd_out === 1'b0);
    chk(lows, 0);
    chk(irq_cause_out, IRQ_TXEMPTY);
  endtask

  initial begin
    repeat (6) @(negedge mclk_in);
    rstn_in = 1'b1;
    @(negedge mclk_in);
    chk({txd_out, rx_valid_out, irq_out, tx_full_out}, 4'h8);
    t_tx_formats;
    t_rx;
    t_rx_fifo;
    t_tx_fifo;
    close_out;
  end

  initial begin
    #5_000_000;
    fails++;
    close_out;
  end
endmodule

bind uart_core uart_core_props uart_core_props_inst (.mclk_in, .rstn_in,
  .line_cfg_in, .irq_en_in, .rx_read_in, .rx_data_out, .rx_valid_out,
  .parity_err_out, .frame_err_out, .overrun_out, .irq_cause_out, .irq_out,
  .txd_out);
`default_nettype wire

/* File: uart_core.sv */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - One start bit, five to eight data bits, one or two stops; one-and-half only with five data bits.
// - Parity even, odd, sticky or none, generated on send and checked on receive.
// - Baud generator divides selected clock by a 16-bit divisor from 1 to 65535.
// - With 24 MHz source, standard rates 50 baud to 115.2 kbaud are reachable.
// - With 16 MHz source, rates 125 kbaud to 1000 kbaud are reachable.
// - Divider settings can reach the MIDI data rate.
// - Writing holding register or transmit FIFO starts framing and sending.
// - Send start, data bits LSB first, optional parity, then stop bits.
// - Transmit and receive are timed by baud tick divided by sixteen.
// - Transmit-empty interrupt when holding register or transmit FIFO empties.
// - FIFO enable bit 0 gives a 16-byte transmit FIFO.
// - In FIFO mode characters go back to back until the FIFO drains.
// - Receiver shifts serial input into its shift register at baud over sixteen.
// - Receive glitch filter drops pulses shorter than two receive clock periods.
// - Received data goes to buffer or FIFO, first bit in bit 0.
// - Receiver checks parity bit and the first stop bit against line settings.
// - Data interrupt on character arrival, or FIFO trigger level in FIFO mode.
// - Interrupts also for character timeout, parity, framing and line errors.
// - Receive FIFO holds 16 bytes; trigger level 1, 4, 8 or 14.
// - Interrupt causes are prioritized; only the highest pending is reported.
module uart_core
  import uart_pkg::*;
(
  input  wire logic                mclk_in,
  input  wire logic                rstn_in,
  input  wire logic                clk24_in,
  input  wire logic                clk16_in,
  input  wire logic                src16_sel_in,
  input  wire logic [15:0]         divisor_in,
  input  wire uart_pkg::line_cfg_t line_cfg_in,
  input  wire logic                fifo_en_in,
  input  wire logic [1:0]          rx_trig_in,
  input  wire logic [3:0]          irq_en_in,
  input  wire logic [7:0]          tx_data_in,
  input  wire logic                tx_write_in,
  output logic                     tx_full_out,
  output logic [7:0]               rx_data_out,
  output logic                     rx_valid_out,
  input  wire logic                rx_read_in,
  output logic                     parity_err_out,
  output logic                     frame_err_out,
  output logic                     overrun_out,
  output uart_pkg::irq_cause_t     irq_cause_out,
  output logic                     irq_out,
  output logic                     txd_out,
  input  wire logic                rxd_in
);
  import uart_pkg::*;

  // Source clock edges: pins from another domain, three flops, rise when 2nd high and 3rd low
  logic [2:0] c24_s_r, c16_s_r, rxd_s_r;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      c24_s_r <= 3'h0;
      c16_s_r <= 3'h0;
      rxd_s_r <= 3'h7;
    end else begin
      c24_s_r <= {c24_s_r[1:0], clk24_in};
      c16_s_r <= {c16_s_r[1:0], clk16_in};
      rxd_s_r <= {rxd_s_r[1:0], rxd_in};
    end
  end
  wire src_s   = src16_sel_in ? c16_s_r[1] : c24_s_r[1];
  wire src_d   = src16_sel_in ? c16_s_r[2] : c24_s_r[2];
  wire src_rise = src_s && !src_d;
  wire rxd_stable = (rxd_s_r[1] == rxd_s_r[2]);

  // Baud generator: divide selected source by divisor (0 treated as 1)
  logic [15:0] div_cnt_r;
  logic        baud_tick_r;
  wire [15:0] div_eff = (divisor_in == 16'h0000) ? DIV_RESET : divisor_in;
  wire div_wrap = src_rise && (div_cnt_r >= div_eff - 16'h0001);
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_cnt_r   <= 16'h0000;
      baud_tick_r <= 1'b0;
    end else begin
      baud_tick_r <= div_wrap;
      if (div_wrap)
        div_cnt_r <= 16'h0000;
      else if (src_rise)
        div_cnt_r <= div_cnt_r + 16'h0001;
    end
  end

  // Glitch filter on receive input
  logic       rxf_r;
  logic [1:0] filt_cnt_r;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rxf_r      <= 1'b1;
      filt_cnt_r <= 2'h0;
    end else if (!rxd_stable || rxd_s_r[2] == rxf_r) begin
      filt_cnt_r <= 2'h0;
    end else if (baud_tick_r) begin
      if (filt_cnt_r == FILT_LEN - 2'h1) begin
        rxf_r      <= rxd_s_r[2];
        filt_cnt_r <= 2'h0;
      end else begin
        filt_cnt_r <= filt_cnt_r + 2'h1;
      end
    end
  end

  // Frame geometry
  wire [3:0] nbits = 4'h5 + {2'b00, line_cfg_in.word_len};
  wire       has_par = (line_cfg_in.parity != PAR_NONE);
  wire       half_stop = (line_cfg_in.stop_len == STOP_ONE_HALF) &&
                         (line_cfg_in.word_len == 2'b00);
  wire       two_stop  = (line_cfg_in.stop_len == STOP_TWO) ||
                         ((line_cfg_in.stop_len == STOP_ONE_HALF) && !half_stop);

  function automatic logic par_bit(input logic [7:0] d, input logic [3:0] n,
                                   input line_cfg_t c);
    logic [7:0] m;
    logic       x;
    m = 8'hff >> (4'h8 - n);
    x = ^(d & m);
    unique case (c.parity)
      PAR_ODD:    par_bit = ~x;
      PAR_EVEN:   par_bit = x;
      PAR_STICKY: par_bit = c.sticky_val;
      PAR_NONE:   par_bit = 1'b0;
    endcase
  endfunction

  // Transmit FIFO
  logic [7:0] tx_mem_r [FIFO_DEPTH];
  logic [FIFO_AW-1:0] tx_wp_r, tx_rp_r;
  logic [FIFO_AW:0]   tx_cnt_r;
  wire [FIFO_AW:0] tx_cap = fifo_en_in ? 5'(FIFO_DEPTH) : 5'h01;
  wire tx_push = tx_write_in && (tx_cnt_r < tx_cap);
  logic tx_pop;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_wp_r  <= '0;
      tx_rp_r  <= '0;
      tx_cnt_r <= '0;
    end else begin
      if (tx_push) begin
        tx_mem_r[tx_wp_r] <= tx_data_in;
        tx_wp_r <= tx_wp_r + 4'h1;
      end
      if (tx_pop)
        tx_rp_r <= tx_rp_r + 4'h1;
      tx_cnt_r <= tx_cnt_r + 5'(tx_push) - 5'(tx_pop);
    end
  end

  // Transmitter
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01
  } tx_state_t;
  tx_state_t  tx_st_r;
  logic [11:0] tx_sh_r;
  logic [3:0]  tx_ovs_r;
  logic [3:0]  tx_left_r;
  logic        tx_half_r;
  wire tx_load = (tx_st_r == TX_IDLE) && (tx_cnt_r != 5'h00) && baud_tick_r;
  assign tx_pop = tx_load;
  wire [7:0] tx_byte = tx_mem_r[tx_rp_r] & (8'hff >> (4'h8 - nbits));
  wire [11:0] tx_frame = has_par ?
    (({4'h0, tx_byte} << 1) |
     (12'(par_bit(tx_byte, nbits, line_cfg_in)) << (nbits + 4'h1)) |
     (12'hfff << (nbits + 4'h2))) :
    ({4'h0, tx_byte} << 1) | (12'hfff << (nbits + 4'h1));
  // A half stop is a second stop bit cut to eight ticks
  wire [3:0] tx_len = nbits + 4'h2 + 4'(has_par) + 4'(two_stop || half_stop);
  wire tx_bit_end = baud_tick_r &&
    (tx_ovs_r == ((tx_left_r == 4'h1 && tx_half_r) ? OVS_HALF : OVS_LAST));

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_st_r   <= TX_IDLE;
      tx_sh_r   <= 12'hfff;
      tx_ovs_r  <= 4'h0;
      tx_left_r <= 4'h0;
      tx_half_r <= 1'b0;
      txd_out   <= 1'b1;
    end else begin
      unique case (tx_st_r)
        TX_IDLE: begin
          txd_out <= 1'b1;
          if (tx_load) begin
            tx_sh_r   <= tx_frame;
            tx_left_r <= tx_len;
            tx_half_r <= half_stop;
            tx_ovs_r  <= 4'h0;
            txd_out   <= 1'b0;
            tx_st_r   <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (baud_tick_r)
            tx_ovs_r <= tx_ovs_r + 4'h1;
          if (tx_bit_end) begin
            tx_ovs_r  <= 4'h0;
            tx_left_r <= tx_left_r - 4'h1;
            if (tx_left_r == 4'h1) begin
              txd_out <= 1'b1;
              tx_st_r <= TX_IDLE;
            end else begin
              tx_sh_r <= {1'b1, tx_sh_r[11:1]};
              txd_out <= tx_sh_r[1];
            end
          end
        end
      endcase
    end
  end
  // Receiver
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_BITS  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;
  rx_state_t   rx_st_r;
  logic [3:0]  rx_ovs_r;
  logic [3:0]  rx_idx_r;
  logic [8:0]  rx_sh_r;
  logic        rxf_d_r;
  logic        rxw_valid_r;
  rx_word_t    rxw_r;
  wire rx_mid = baud_tick_r && (rx_ovs_r == OVS_MID);
  wire [3:0] rx_dbits = nbits + 4'(has_par);
  wire [7:0] rx_data_m = rx_sh_r[7:0] & (8'hff >> (4'h8 - nbits));
  wire rx_perr = has_par &&
    (rx_sh_r[nbits] != par_bit(rx_data_m, nbits, line_cfg_in));
  logic buf_ready;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_st_r     <= RX_IDLE;
      rx_ovs_r    <= 4'h0;
      rx_idx_r    <= 4'h0;
      rx_sh_r     <= 9'h000;
      rxf_d_r     <= 1'b1;
      rxw_valid_r <= 1'b0;
      rxw_r       <= '0;
    end else begin
      rxf_d_r <= rxf_r;
      if (rxw_valid_r && buf_ready)
        rxw_valid_r <= 1'b0;
      if (baud_tick_r)
        rx_ovs_r <= rx_ovs_r + 4'h1;
      unique case (rx_st_r)
        RX_IDLE: begin
          rx_ovs_r <= 4'h0;
          if (rxf_d_r && !rxf_r)
            rx_st_r <= RX_START;
        end
        RX_START: begin
          if (rx_mid) begin
            rx_idx_r <= 4'h0;
            rx_st_r  <= rxf_r ? RX_IDLE : RX_BITS;
          end
        end
        RX_BITS: begin
          if (rx_mid) begin
            rx_sh_r[rx_idx_r] <= rxf_r;
            rx_idx_r <= rx_idx_r + 4'h1;
            if (rx_idx_r == rx_dbits - 4'h1)
              rx_st_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_mid) begin
            rxw_r.data       <= rx_data_m;
            rxw_r.parity_err <= rx_perr;
            rxw_r.frame_err  <= !rxf_r;
            rxw_valid_r      <= 1'b1;
            rx_st_r          <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // Two-entry buffer absorbs a word while the receive FIFO is full
  rx_word_t buf_word;
  logic     buf_valid;
  wire      rxf_has_room;
  uart_skid_buf u_buf (
    .mclk_in     (mclk_in),
    .rstn_in     (rstn_in),
    .s_data_in   (rxw_r),
    .s_valid_in  (rxw_valid_r),
    .s_ready_out (buf_ready),
    .m_data_out  (buf_word),
    .m_valid_out (buf_valid),
    .m_ready_in  (rxf_has_room)
  );
  wire rx_overrun = rxw_valid_r && !buf_ready;

  // Receive FIFO (depth 1 when FIFOs are off = plain buffer register)
  rx_word_t rx_mem_r [FIFO_DEPTH];
  logic [FIFO_AW-1:0] rx_wp_r, rx_rp_r;
  logic [FIFO_AW:0]   rx_cnt_r;
  wire [FIFO_AW:0] rx_cap = fifo_en_in ? 5'(FIFO_DEPTH) : 5'h01;
  assign rxf_has_room = (rx_cnt_r < rx_cap);
  wire rx_push = buf_valid && rxf_has_room;
  wire rx_pop  = rx_read_in && (rx_cnt_r != 5'h00);
  wire rx_word_t rx_head = rx_mem_r[rx_rp_r];

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_wp_r  <= '0;
      rx_rp_r  <= '0;
      rx_cnt_r <= '0;
    end else begin
      if (rx_push) begin
        rx_mem_r[rx_wp_r] <= buf_word;
        rx_wp_r <= rx_wp_r + 4'h1;
      end
      if (rx_pop)
        rx_rp_r <= rx_rp_r + 4'h1;
      rx_cnt_r <= rx_cnt_r + 5'(rx_push) - 5'(rx_pop);
    end
  end

  // Character timeout: data waiting with no activity for a few characters
  logic [9:0] tout_r;
  logic       tout_flag_r;
  wire rx_activity = rx_push || rx_pop || (rx_st_r != RX_IDLE);
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tout_r      <= 10'h000;
      tout_flag_r <= 1'b0;
    end else if (rx_activity || !fifo_en_in || rx_cnt_r == 5'h00) begin
      tout_r      <= 10'h000;
      tout_flag_r <= 1'b0;
    end else if (baud_tick_r && tout_r != TOUT_TICKS) begin
      tout_r <= tout_r + 10'h001;
    end else if (tout_r == TOUT_TICKS) begin
      tout_flag_r <= 1'b1;
    end
  end

  // Line status: sticky, cleared by read (transmit-empty by a write); a new event wins over the clear
  logic perr_r, ferr_r, oerr_r, txe_r, tx_busy_d_r;
  wire tx_empty_evt = (tx_cnt_r == 5'h00) && tx_busy_d_r;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      perr_r      <= 1'b0;
      ferr_r      <= 1'b0;
      oerr_r      <= 1'b0;
      txe_r       <= 1'b0;
      tx_busy_d_r <= 1'b0;
    end else begin
      tx_busy_d_r <= (tx_cnt_r != 5'h00);
      perr_r <= (rx_push && buf_word.parity_err) || (perr_r && !rx_read_in);
      ferr_r <= (rx_push && buf_word.frame_err) || (ferr_r && !rx_read_in);
      oerr_r <= rx_overrun || (oerr_r && !rx_read_in);
      txe_r  <= tx_empty_evt || (txe_r && !tx_write_in);
    end
  end

  wire [4:0] trig = (rx_trig_in == 2'b00) ? TRIG_1 :
                    (rx_trig_in == 2'b01) ? TRIG_4 :
                    (rx_trig_in == 2'b10) ? TRIG_8 : TRIG_14;
  wire rx_data_irq = fifo_en_in ? (rx_cnt_r >= trig) :
                                  (rx_cnt_r != 5'h00);
  wire line_irq = irq_en_in[2] && (perr_r || ferr_r || oerr_r);
  wire irq_cause_t cause_nxt =
    line_irq                          ? IRQ_LINE    :
    (irq_en_in[0] && rx_data_irq)     ? IRQ_RXDATA  :
    (irq_en_in[0] && tout_flag_r)     ? IRQ_TIMEOUT :
    (irq_en_in[1] && txe_r)           ? IRQ_TXEMPTY : IRQ_NONE;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_cause_out  <= IRQ_NONE;
      irq_out        <= 1'b0;
      rx_data_out    <= 8'h00;
      rx_valid_out   <= 1'b0;
      parity_err_out <= 1'b0;
      frame_err_out  <= 1'b0;
      overrun_out    <= 1'b0;
      tx_full_out    <= 1'b0;
    end else begin
      irq_cause_out  <= cause_nxt;
      irq_out        <= (cause_nxt != IRQ_NONE);
      rx_data_out    <= rx_head.data;
      rx_valid_out   <= (rx_cnt_r != 5'h00) && !rx_pop;
      parity_err_out <= perr_r;
      frame_err_out  <= ferr_r;
      overrun_out    <= oerr_r;
      tx_full_out    <= (tx_cnt_r >= tx_cap);
    end
  end

endmodule

`default_nettype wire

/* File: uart_core_props.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_core_props
  import uart_pkg::*;
(
  input wire logic                 mclk_in,
  input wire logic                 rstn_in,
  input wire uart_pkg::line_cfg_t  line_cfg_in,
  input wire logic [3:0]           irq_en_in,
  input wire logic                 rx_read_in,
  input wire logic [7:0]           rx_data_out,
  input wire logic                 rx_valid_out,
  input wire logic                 parity_err_out,
  input wire logic                 frame_err_out,
  input wire logic                 overrun_out,
  input wire uart_pkg::irq_cause_t irq_cause_out,
  input wire logic                 irq_out,
  input wire logic                 txd_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);

  idle_high_a: assert property ($rose(rstn_in) |-> txd_out)
    else $error("serial out not idle after reset");
  start_len_a: assert property (
    $fell(txd_out) |-> (!txd_out)[*8])
    else $error("start bit too short");
  rx_hold_a: assert property (
    (rx_valid_out && !rx_read_in)[*2] |=> rx_valid_out)
    else $error("receive data lost without a read");
  rx_data_hold_a: assert property (
    (rx_valid_out && !rx_read_in)[*4] |=> $stable(rx_data_out))
    else $error("receive data changed without a read");
  perr_sticky_a: assert property (
    parity_err_out && !rx_read_in && !$past(rx_read_in) |=> parity_err_out)
    else $error("parity flag dropped without a read");
  ferr_sticky_a: assert property (
    frame_err_out && !rx_read_in && !$past(rx_read_in) |=> frame_err_out)
    else $error("framing flag dropped without a read");
  line_prio_a: assert property (
    $rose(parity_err_out || frame_err_out || overrun_out) && irq_en_in[2]
    |-> ##[0:3] irq_cause_out == IRQ_LINE)
    else $error("line status not reported first");
  irq_off_a: assert property (
    (irq_en_in == 4'h0)[*3] |-> !irq_out)
    else $error("interrupt while all sources disabled");
  short_word_a: assert property (
    rx_valid_out && line_cfg_in.word_len == 2'h0 |-> rx_data_out[7:5] == 3'h0)
    else $error("upper bits set in five bit character");
endmodule
`default_nettype wire

/* File: uart_pkg.sv */
package uart_pkg;

  localparam int DATA_W      = 8;
  localparam int FIFO_DEPTH  = 16;
  localparam int FIFO_AW     = 4;
  localparam int OVS         = 16;
  localparam int CLK_HZ      = 20_000_000;
  localparam int TOUT_CHARS  = 4;
  localparam logic [15:0] DIV_RESET = 16'h0001;
  localparam logic [3:0]  OVS_LAST  = 4'hf;
  localparam logic [3:0]  OVS_MID   = 4'h7;
  localparam logic [3:0]  OVS_HALF  = 4'h7;
  localparam logic [1:0]  FILT_LEN  = 2'h2;
  localparam logic [9:0]  TOUT_TICKS = 10'h0280;
  localparam logic [4:0]  TRIG_1    = 5'h01;
  localparam logic [4:0]  TRIG_4    = 5'h04;
  localparam logic [4:0]  TRIG_8    = 5'h08;
  localparam logic [4:0]  TRIG_14   = 5'h0e;
  localparam int BUF_DEPTH   = 2;

  typedef enum logic [1:0] {
    PAR_NONE   = 2'b00,
    PAR_ODD    = 2'b01,
    PAR_EVEN   = 2'b10,
    PAR_STICKY = 2'b11
  } parity_t;

  typedef enum logic [1:0] {
    STOP_ONE      = 2'b00,
    STOP_ONE_HALF = 2'b01,
    STOP_TWO      = 2'b10
  } stop_t;

  typedef enum logic [2:0] {
    IRQ_NONE    = 3'b000,
    IRQ_LINE    = 3'b001,
    IRQ_RXDATA  = 3'b010,
    IRQ_TIMEOUT = 3'b011,
    IRQ_TXEMPTY = 3'b100
  } irq_cause_t;

  typedef struct packed {
    logic [1:0] word_len;
    stop_t      stop_len;
    parity_t    parity;
    logic       sticky_val;
  } line_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic       parity_err;
    logic       frame_err;
  } rx_word_t;

endpackage

/* File: uart_remote_model.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_remote_model
  import uart_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        txd_in,
  output logic             rxd_out,
  input  wire logic [31:0] bit_cyc_in
);
  int now = 0;
  always @(posedge mclk_in) now <= now + 1;
  initial rxd_out = 1'b1;

  function automatic logic par_bit(line_cfg_t c, logic [7:0] d);
    logic [7:0] m;
    m = (8'hff >> (2'h3 - c.word_len)) & d;
    if (c.parity == PAR_ODD) return ~^m;
    if (c.parity == PAR_EVEN) return ^m;
    return c.sticky_val;
  endfunction

  function automatic int stop_ticks(line_cfg_t c);
    if (c.stop_len == STOP_ONE) return 16;
    if (c.stop_len == STOP_ONE_HALF && c.word_len == 2'h0)
      return 24;
    return 32;
  endfunction

  task automatic drive(input logic v, input int n);
    rxd_out = v;
    repeat (n) @(negedge mclk_in);
  endtask

  // Error flags corrupt parity or pull the stop bit low
  task automatic send(input line_cfg_t c, input logic [7:0] d,
                      input logic bad_par, input logic bad_stop);
    @(negedge mclk_in);
    drive(1'b0, bit_cyc_in);
    for (int i = 0; i < 5 + c.word_len; i++) begin
      drive(d[i], bit_cyc_in);
    end
    if (c.parity != PAR_NONE) begin
      drive(par_bit(c, d) ^ bad_par, bit_cyc_in);
    end
    drive(!bad_stop, bit_cyc_in * stop_ticks(c) / 16);
    rxd_out = 1'b1;
  endtask

  // Returns at mid stop bit so back-to-back starts are caught
  task automatic recv(input line_cfg_t c, output logic [7:0] d,
                      output logic p, output int t0);
    d = 8'h00;
    p = 1'b0;
    t0 = now;
    while (txd_in === 1'b1 && now - t0 < 20000) @(posedge mclk_in);
    t0 = now;
    repeat (bit_cyc_in * 3 / 2) @(posedge mclk_in);
    for (int i = 0; i < 5 + c.word_len; i++) begin
      d[i] = txd_in;
      repeat (bit_cyc_in) @(posedge mclk_in);
    end
    if (c.parity != PAR_NONE) begin
      p = txd_in;
      repeat (bit_cyc_in) @(posedge mclk_in);
    end
  endtask
endmodule
`default_nettype wire

/* File: uart_skid_buf.sv */
`timescale 1ns/1ps
`default_nettype none

module uart_skid_buf
  import uart_pkg::*;
(
  input  wire logic     mclk_in,
  input  wire logic     rstn_in,
  input  wire rx_word_t s_data_in,
  input  wire logic     s_valid_in,
  output logic          s_ready_out,
  output rx_word_t      m_data_out,
  output logic          m_valid_out,
  input  wire logic     m_ready_in
);
  rx_word_t  mem_r [BUF_DEPTH];
  logic      wp_r;
  logic      rp_r;
  logic [1:0] cnt_r;
  wire push = s_valid_in && s_ready_out;
  wire pop  = m_valid_out && m_ready_in;

  assign s_ready_out = (cnt_r != 2'(BUF_DEPTH));
  assign m_valid_out = (cnt_r != 2'h0);
  assign m_data_out  = mem_r[rp_r];

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end else begin
      if (push) begin
        mem_r[wp_r] <= s_data_in;
        wp_r <= ~wp_r;
      end
      if (pop)
        rp_r <= ~rp_r;
      cnt_r <= cnt_r + 2'(push) - 2'(pop);
    end
  end
endmodule

`default_nettype wire
